// ===== logic/msp_top.sv
/*
 * Motion sync pulse output: byte-wide command link for reading and writing
 * the output settings, the settings store, the sync output pin and the
 * target-window check.
 * Assumes bytes arrive with a valid strobe, one byte per accepted cycle, and
 * that motion state, step pulses and position error come from the motion core.
 */
// Notes on behaviour
// RULE1 - Enable flag: pin follows pulse logic.
// RULE2 - Enable clear: pin holds fixed-level flag.
// RULE3 - Polarity flag set makes low active.
// RULE4 - Width counts steps or microseconds by flag.
// RULE5 - Pulse on every movement start.
// RULE6 - Pulse on every movement stop.
// RULE7 - Pulse whenever step count reaches period.
// RULE8 - Read command returns sixteen-byte settings answer.
// RULE9 - Write command stores settings, echoes code.
// RULE10 - Target reached within steps/microsteps window.
// RULE11 - Host opens write with its command code.
// RULE12 - Reads return last written or defaults.
// RULE13 - Settings frames end in checked checksum.
`timescale 1ns/1ps
module msp_top #(
    parameter logic [7:0] FLAGS_DEFAULT = msp_pkg::DEF_FLAGS,
    parameter logic [15:0] WIDTH_DEFAULT = msp_pkg::DEF_WIDTH,
    parameter logic [15:0] PERIOD_DEFAULT = msp_pkg::DEF_PERIOD
) (
    input wire logic I_SYS_CLK,
    input wire logic I_RST,
    input wire logic [7:0] i_RX_DATA,
    input wire logic i_RX_VALID,
    output logic o_RX_READY,
    output logic [7:0] o_TX_DATA,
    output logic o_TX_VALID,
    input wire logic i_TX_READY,
    output logic o_REQ_REJECTED,
    input wire logic i_MOVING,
    input wire logic i_STEP,
    input wire logic i_STEPPER_MOTOR,
    input wire logic signed [31:0] i_POS_ERR_STEPS,
    input wire logic signed [8:0] i_POS_ERR_USTEPS,
    output logic o_SYNC_OUT,
    output logic o_TARGET_REACHED
);
    // Reflected 16-bit checksum over the ten payload bytes, first byte first.
    function automatic logic [15:0] msp_crc(input logic [79:0] d);
        logic [15:0] c;
        c = msp_pkg::CRC_INIT;
        for (int i = 0; i < msp_pkg::PAYLOAD_BYTES; i++) begin
            c = c ^ {8'h00, d[8*i +: 8]};
            for (int b = 0; b < 8; b++) begin
                c = c[0] ? ((c >> 1) ^ msp_pkg::CRC_POLY) : (c >> 1);
            end
        end
        return c;
    endfunction

    msp_pkg::msp_state_t state;
    msp_pkg::msp_state_t next_state;
    logic [31:0] cmd_win;
    logic [31:0] next_cmd_win;
    logic [95:0] body;
    logic [95:0] next_body;
    logic [127:0] tx_buf;
    logic [127:0] next_tx_buf;
    logic [4:0] cnt;
    logic [4:0] next_cnt;
    logic rejected;
    logic next_rejected;
    logic [7:0] flags;
    logic [7:0] next_flags;
    logic [15:0] width;
    logic [15:0] next_width;
    logic [15:0] period;
    logic [15:0] next_period;
    logic [31:0] win_steps;
    logic [31:0] next_win_steps;
    logic [7:0] win_usteps;
    logic [7:0] next_win_usteps;
    logic [79:0] cur_payload;
    logic [15:0] cur_crc;
    logic rx_take;

    assign cur_payload = {win_usteps, win_steps, period, width, flags};
    assign cur_crc = msp_crc(cur_payload);
    // Requests are not taken while an answer is going out.
    assign o_RX_READY = (state != msp_pkg::MSP_REPLY);
    assign rx_take = i_RX_VALID && o_RX_READY;
    assign o_TX_VALID = (state == msp_pkg::MSP_REPLY);
    assign o_TX_DATA = tx_buf[7:0];
    assign o_REQ_REJECTED = rejected;

    // Command parser; the sliding code window resynchronises after junk bytes.
    always_comb begin
        next_state = state;
        next_cmd_win = cmd_win;
        next_body = body;
        next_tx_buf = tx_buf;
        next_cnt = cnt;
        next_rejected = 1'b0;
        next_flags = flags;
        next_width = width;
        next_period = period;
        next_win_steps = win_steps;
        next_win_usteps = win_usteps;
        case (state)
            msp_pkg::MSP_HUNT: begin
                if (rx_take) begin
                    next_cmd_win = {i_RX_DATA, cmd_win[31:8]};
                    if (next_cmd_win == msp_pkg::CMD_READ) begin
                        // Answer carries the stored set and a fresh checksum.
                        next_tx_buf = {cur_crc, cur_payload, msp_pkg::CMD_READ}; // RULE8 RULE12
                        next_cnt = 5'(msp_pkg::READ_ANSWER_BYTES - 1);
                        next_state = msp_pkg::MSP_REPLY;
                    end else if (next_cmd_win == msp_pkg::CMD_WRITE) begin // RULE11
                        next_cnt = '0;
                        next_state = msp_pkg::MSP_BODY;
                    end
                end
            end
            msp_pkg::MSP_BODY: begin
                if (rx_take) begin
                    next_body = {i_RX_DATA, body[95:8]};
                    next_cnt = cnt + 5'h01;
                    if (cnt == 5'(msp_pkg::WRITE_BODY_BYTES - 1)) begin
                        next_cmd_win = '0;
                        if (msp_crc(next_body[79:0]) == next_body[95:80]) begin // RULE13
                            next_flags = next_body[msp_pkg::POS_FLAGS +: 8]; // RULE9
                            next_width = next_body[msp_pkg::POS_WIDTH +: 16];
                            next_period = next_body[msp_pkg::POS_PERIOD +: 16];
                            next_win_steps = next_body[msp_pkg::POS_WIN_STEPS +: 32];
                            next_win_usteps = next_body[msp_pkg::POS_WIN_USTEPS +: 8];
                            next_tx_buf = {96'h0, msp_pkg::CMD_WRITE};
                            next_cnt = 5'(msp_pkg::WRITE_ECHO_BYTES - 1);
                            next_state = msp_pkg::MSP_REPLY;
                        end else begin
                            // A bad frame leaves the settings untouched and gets no answer.
                            next_rejected = 1'b1;
                            next_state = msp_pkg::MSP_HUNT;
                        end
                    end
                end
            end
            msp_pkg::MSP_REPLY: begin
                if (i_TX_READY) begin
                    next_tx_buf = {8'h00, tx_buf[127:8]};
                    next_cnt = cnt - 5'h01;
                    if (cnt == '0) begin
                        next_cmd_win = '0;
                        next_state = msp_pkg::MSP_HUNT;
                    end
                end
            end
            default: begin
                next_state = msp_pkg::MSP_HUNT;
            end
        endcase
    end

    // Link and settings registers; defaults stand until the first good write.
    always_ff @(posedge I_SYS_CLK) begin
        if (I_RST) begin
            state <= msp_pkg::MSP_HUNT;
            cmd_win <= 32'h00000000;
            body <= '0;
            tx_buf <= '0;
            cnt <= 5'h00;
            rejected <= 1'b0;
            flags <= FLAGS_DEFAULT; // RULE12
            width <= WIDTH_DEFAULT;
            period <= PERIOD_DEFAULT;
            win_steps <= msp_pkg::DEF_WIN_STEPS;
            win_usteps <= msp_pkg::DEF_WIN_USTEPS;
        end else begin
            state <= next_state;
            cmd_win <= next_cmd_win;
            body <= next_body;
            tx_buf <= next_tx_buf;
            cnt <= next_cnt;
            rejected <= next_rejected;
            flags <= next_flags;
            width <= next_width;
            period <= next_period;
            win_steps <= next_win_steps;
            win_usteps <= next_win_usteps;
        end
    end

    logic pulse_active;

    msp_pulse_gen #(
        .CNT_W(16)
    ) u_pulse (
        .i_clk(I_SYS_CLK),
        .i_rst(I_RST),
        .i_flags(flags), // RULE5 RULE6
        .i_width(width), // RULE4
        .i_period(period), // RULE7
        .i_moving(i_MOVING),
        .i_step(i_STEP),
        .o_active(pulse_active)
    );

    logic sync_out;
    logic next_sync_out;
    logic reached;
    logic next_reached;
    logic [31:0] abs_steps;
    logic [8:0] abs_usteps;

    // Pin level and window check; both are registered so the pin never glitches.
    always_comb begin
        if (flags[msp_pkg::FLAG_LOGIC_ENABLE]) begin // RULE1
            next_sync_out = pulse_active ^ flags[msp_pkg::FLAG_POLARITY_LOW]; // RULE3
        end else begin
            next_sync_out = flags[msp_pkg::FLAG_FIXED_LEVEL]; // RULE2
        end
        abs_steps = i_POS_ERR_STEPS[31] ? 32'(-i_POS_ERR_STEPS) : i_POS_ERR_STEPS;
        abs_usteps = i_POS_ERR_USTEPS[8] ? 9'(-i_POS_ERR_USTEPS) : i_POS_ERR_USTEPS;
        // Microstep part of the window matters only for stepper motors.
        next_reached = (abs_steps <= win_steps)
            && (!i_STEPPER_MOTOR || abs_usteps <= {1'b0, win_usteps}); // RULE10
    end

    // Pin and window flip-flops; reset leaves the pin low as the default flags ask.
    always_ff @(posedge I_SYS_CLK) begin
        if (I_RST) begin
            sync_out <= 1'b0;
            reached <= 1'b0;
        end else begin
            sync_out <= next_sync_out;
            reached <= next_reached;
        end
    end

    assign o_SYNC_OUT = sync_out;
    assign o_TARGET_REACHED = reached;
endmodule

// ===== include/msp_pkg.sv
/*
 * Shared constants of the motion sync pulse output block: command codes,
 * settings layout within a settings frame, factory defaults and timing.
 * Assumes a 200 MHz system clock and little-endian byte order on the link.
 */
package msp_pkg;
    // Command codes as 32-bit words, first byte on the link in bits 7:0.
    localparam logic [31:0] CMD_READ = 32'h6F6E7367;
    localparam logic [31:0] CMD_WRITE = 32'h6F6E7373;

    // Frame sizes in bytes.
    localparam int READ_ANSWER_BYTES = 16;
    localparam int WRITE_ECHO_BYTES = 4;
    localparam int WRITE_BODY_BYTES = 12;
    localparam int PAYLOAD_BYTES = 10;

    // Bit positions of the settings fields within the 80-bit payload.
    localparam int POS_FLAGS = 0;
    localparam int POS_WIDTH = 8;
    localparam int POS_PERIOD = 24;
    localparam int POS_WIN_STEPS = 40;
    localparam int POS_WIN_USTEPS = 72;

    // Bits of the output flags field.
    localparam int FLAG_LOGIC_ENABLE = 0;
    localparam int FLAG_FIXED_LEVEL = 1;
    localparam int FLAG_POLARITY_LOW = 2;
    localparam int FLAG_UNIT_STEPS = 3;
    localparam int FLAG_ON_START = 4;
    localparam int FLAG_ON_STOP = 5;
    localparam int FLAG_PERIODIC = 6;

    // Factory default settings.
    localparam logic [7:0] DEF_FLAGS = 8'h00;
    localparam logic [15:0] DEF_WIDTH = 16'h000A;
    localparam logic [15:0] DEF_PERIOD = 16'h0064;
    localparam logic [31:0] DEF_WIN_STEPS = 32'h00000000;
    localparam logic [7:0] DEF_WIN_USTEPS = 8'h00;

    // Checksum seed and reflected polynomial.
    localparam logic [15:0] CRC_INIT = 16'hFFFF;
    localparam logic [15:0] CRC_POLY = 16'hA001;

    // Width time unit is one microsecond.
    localparam int CLK_PERIOD_PS = 5000;
    localparam int WIDTH_UNIT_PS = 1000000;
    localparam int CYC_PER_UNIT = WIDTH_UNIT_PS / CLK_PERIOD_PS;

    typedef enum logic [1:0] {
        MSP_HUNT = 2'b00,
        MSP_BODY = 2'b01,
        MSP_REPLY = 2'b10
    } msp_state_t;
endpackage

// ===== logic/msp_pulse_gen.sv
/*
 * Sync pulse generator: detects motion start and stop, counts steps for
 * periodic pulses and times each pulse in microseconds or in steps.
 * Assumes motion and step inputs are synchronous to the system clock.
 */
`timescale 1ns/1ps
module msp_pulse_gen #(
    parameter int CNT_W = 16
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic [7:0] i_flags,
    input wire logic [CNT_W-1:0] i_width,
    input wire logic [CNT_W-1:0] i_period,
    input wire logic i_moving,
    input wire logic i_step,
    output logic o_active
);
    localparam logic [7:0] UNIT_LAST = 8'(msp_pkg::CYC_PER_UNIT - 1);

    logic moving_d;
    logic next_moving_d;
    logic [CNT_W-1:0] per_cnt;
    logic [CNT_W-1:0] next_per_cnt;
    logic [CNT_W-1:0] remain;
    logic [CNT_W-1:0] next_remain;
    logic [7:0] unit_cnt;
    logic [7:0] next_unit_cnt;
    logic active;
    logic next_active;
    logic per_fire;
    logic fire;
    logic tick;

    // Trigger sources and pulse timing; a new trigger restarts the width.
    always_comb begin
        next_moving_d = i_moving;
        next_per_cnt = per_cnt;
        per_fire = 1'b0;
        if (!i_flags[msp_pkg::FLAG_PERIODIC]) begin
            next_per_cnt = '0;
        end else if (i_step) begin
            if (i_period != '0 && per_cnt + 1'b1 >= i_period) begin // RULE7
                per_fire = 1'b1;
                next_per_cnt = '0;
            end else begin
                next_per_cnt = per_cnt + 1'b1;
            end
        end
        fire = per_fire
            | (i_flags[msp_pkg::FLAG_ON_START] & i_moving & ~moving_d) // RULE5
            | (i_flags[msp_pkg::FLAG_ON_STOP] & ~i_moving & moving_d); // RULE6
        next_remain = remain;
        next_unit_cnt = unit_cnt;
        next_active = active;
        tick = 1'b0;
        if (fire && i_width != '0) begin
            next_remain = i_width;
            next_unit_cnt = '0;
            next_active = 1'b1;
        end else if (active) begin
            // Width counts steps or whole microseconds.
            if (i_flags[msp_pkg::FLAG_UNIT_STEPS]) begin // RULE4
                tick = i_step;
            end else if (unit_cnt == UNIT_LAST) begin
                tick = 1'b1;
                next_unit_cnt = '0;
            end else begin
                next_unit_cnt = unit_cnt + 8'h01;
            end
            if (tick) begin
                next_remain = remain - 1'b1;
                if (remain <= 1) begin
                    next_active = 1'b0;
                end
            end
        end
    end

    // State registers.
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            moving_d <= 1'b0;
            per_cnt <= '0;
            remain <= '0;
            unit_cnt <= 8'h00;
            active <= 1'b0;
        end else begin
            moving_d <= next_moving_d;
            per_cnt <= next_per_cnt;
            remain <= next_remain;
            unit_cnt <= next_unit_cnt;
            active <= next_active;
        end
    end

    assign o_active = active;
endmodule

// ===== verif/msp_host.sv
/*
 * Host model for the sync pulse output link: sends request bytes and takes
 * answer bytes, promptly or with a stall after each byte.
 * Assumes the bench calls its tasks in step with the system clock.
 */
`timescale 1ns/1ps
module msp_host (
    input wire logic clk,
    input wire logic rx_ready,
    input wire logic [7:0] tx_data,
    input wire logic tx_valid,
    output logic [7:0] rx_data,
    output logic rx_valid,
    output logic tx_ready
);
    logic slow = 1'b0;

    // The link starts idle with the host ready to take answers.
    initial begin
        rx_data = 8'h00;
        rx_valid = 1'b0;
        tx_ready = 1'b1;
    end

    // A byte is held until taken; the next one may follow at once.
    task automatic put(input logic [7:0] b);
        rx_data <= b;
        rx_valid <= 1'b1;
        do @(posedge clk); while (rx_ready !== 1'b1);
    endtask

    // Released data keeps changing so a stale byte can never pass as new.
    task automatic idle();
        rx_valid <= 1'b0;
        rx_data <= ~rx_data;
    endtask

    // Slow mode drops ready for one cycle after each byte taken.
    task automatic get(output logic [7:0] b);
        do @(posedge clk); while (!(tx_valid === 1'b1 && tx_ready === 1'b1));
        b = tx_data;
        if (slow) begin
            tx_ready <= 1'b0;
            @(posedge clk);
            tx_ready <= 1'b1;
        end
    endtask

    // Sender checksum over the ten payload bytes.
    function automatic logic [15:0] crc(input logic [7:0] p[10]);
        logic [15:0] c;
        c = msp_pkg::CRC_INIT;
        for (int i = 0; i < 10; i++) begin
            c ^= {8'h00, p[i]};
            for (int k = 0; k < 8; k++)
                c = c[0] ? (c >> 1) ^ msp_pkg::CRC_POLY : c >> 1;
        end
        return c;
    endfunction
endmodule

// ===== verif/msp_top_chk.sv
/*
 * Checker for the sync pulse output block: link handshake and answer shape.
 * Assumes it is bound to msp_top and sees only that module's ports.
 */
`timescale 1ns/1ps
module msp_top_chk (
    input wire logic I_SYS_CLK,
    input wire logic I_RST,
    input wire logic [7:0] i_RX_DATA,
    input wire logic i_RX_VALID,
    input wire logic o_RX_READY,
    input wire logic [7:0] o_TX_DATA,
    input wire logic o_TX_VALID,
    input wire logic i_TX_READY,
    input wire logic o_REQ_REJECTED,
    input wire logic o_SYNC_OUT
);
    default clocking cb @(posedge I_SYS_CLK); endclocking
    default disable iff (I_RST);
    logic [7:0] rx;

    // Bytes actually taken; zero stands for no byte, as no code holds one.
    assign rx = (i_RX_VALID && o_RX_READY) ? i_RX_DATA : 8'h00;

    sequence s_read_code;
        rx == 8'h67 ##1 rx == 8'h73 ##1 rx == 8'h6E ##1 rx == 8'h6F;
    endsequence

    a_read_answer: assert property (s_read_code |=> o_TX_VALID && o_TX_DATA == 8'h67)
        else $error("read code not answered");
    a_busy_no_rx: assert property (o_TX_VALID |-> !o_RX_READY)
        else $error("request taken while answering");
    // A read answer taken without stalls must close after exactly sixteen bytes.
    a_read_len: assert property (
        $rose(o_TX_VALID) && o_TX_DATA == 8'h67 ##0 i_TX_READY [*8] ##1 i_TX_READY [*8]
        |=> !o_TX_VALID)
        else $error("read answer not sixteen bytes");
    a_tx_hold: assert property (
        o_TX_VALID && !i_TX_READY |=> o_TX_VALID && $stable(o_TX_DATA))
        else $error("answer byte lost during stall");
    a_first_code: assert property ($rose(o_TX_VALID) |-> o_TX_DATA inside {8'h67, 8'h73})
        else $error("answer does not open with code");
    a_echo_len: assert property (
        $rose(o_TX_VALID) && o_TX_DATA == 8'h73 ##0 i_TX_READY [*4] |=> !o_TX_VALID)
        else $error("echo not four bytes");
    a_ready_back: assert property ($fell(o_TX_VALID) |-> o_RX_READY)
        else $error("link not ready after answer");
    a_rej_pulse: assert property (o_REQ_REJECTED |=> !o_REQ_REJECTED)
        else $error("reject longer than one cycle");
    a_rej_silent: assert property (o_REQ_REJECTED |-> !o_TX_VALID ##1 !o_TX_VALID)
        else $error("rejected write answered");
    a_reset_idle: assert property (
        $fell(I_RST) |-> !o_TX_VALID && !o_SYNC_OUT && o_RX_READY)
        else $error("outputs not idle after reset");

    c_read: cover property (s_read_code);
    c_reject: cover property (o_REQ_REJECTED);
    c_stall: cover property (o_TX_VALID && !i_TX_READY);
endmodule

bind msp_top msp_top_chk u_chk (.I_SYS_CLK, .I_RST, .i_RX_DATA, .i_RX_VALID, .o_RX_READY,
    .o_TX_DATA, .o_TX_VALID, .i_TX_READY, .o_REQ_REJECTED, .o_SYNC_OUT);

// ===== verif/tb_msp_top.sv
/*
 * Bench for the sync pulse output block: settings frames through the host
 * model, motion and step stimulus, pin timing and target window.
 * Assumes a 200 MHz clock and the factory defaults of msp_pkg.
 */
`timescale 1ns/1ps
module tb_msp_top;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic moving = 1'b0;
    logic step = 1'b0;
    logic stepper = 1'b1;
    logic signed [31:0] err_s = 32'sh0;
    logic signed [8:0] err_u = 9'sh0;
    logic [7:0] rx_data, tx_data;
    logic rx_valid, rx_ready, tx_valid, tx_ready, rejected, sync_out, reached;
    logic [7:0] pl[10];
    logic [7:0] ans[16];
    int n_fail = 0;
    int compares = 0;

    // Half period of 2.5 ns gives the 200 MHz system clock.
    always #2.5 clk = ~clk;

    msp_top dut (.I_SYS_CLK(clk), .I_RST(rst), .i_RX_DATA(rx_data), .i_RX_VALID(rx_valid),
        .o_RX_READY(rx_ready), .o_TX_DATA(tx_data), .o_TX_VALID(tx_valid),
        .i_TX_READY(tx_ready), .o_REQ_REJECTED(rejected), .i_MOVING(moving), .i_STEP(step),
        .i_STEPPER_MOTOR(stepper), .i_POS_ERR_STEPS(err_s), .i_POS_ERR_USTEPS(err_u),
        .o_SYNC_OUT(sync_out), .o_TARGET_REACHED(reached));
    msp_host host (.clk(clk), .rx_ready(rx_ready), .tx_data(tx_data), .tx_valid(tx_valid),
        .rx_data(rx_data), .rx_valid(rx_valid), .tx_ready(tx_ready));

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            n_fail++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic wrap_up();
        if (n_fail == 0 && compares > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // Payload bytes, little endian, in frame order.
    task automatic mk(input logic [7:0] f, input logic [15:0] w, p, input logic [31:0] s,
        input logic [7:0] u);
        pl = '{f, w[7:0], w[15:8], p[7:0], p[15:8], s[7:0], s[15:8], s[23:16], s[31:24], u};
    endtask

    task automatic put_code(input logic [31:0] c);
        for (int i = 0; i < 4; i++) host.put(c[8*i +: 8]);
    endtask

    // Write frame; a bad one flips the lowest checksum bit and must be dropped silently.
    task automatic wr(input logic [7:0] f, input logic [15:0] w, p, input logic [31:0] s,
        input logic [7:0] u, input logic bad);
        logic [15:0] c;
        logic [7:0] b;
        logic hit;
        mk(f, w, p, s, u);
        c = host.crc(pl) ^ {15'h0000, bad};
        put_code(msp_pkg::CMD_WRITE);
        for (int i = 0; i < 10; i++) host.put(pl[i]);
        host.put(c[7:0]);
        host.put(c[15:8]);
        host.idle();
        hit = 1'b0;
        if (bad) begin
            repeat (4) begin
                @(posedge clk);
                hit |= rejected;
            end
            chk(hit, 1'b1);
            chk(tx_valid, 1'b0);
        end else begin
            for (int i = 0; i < 4; i++) begin
                host.get(b);
                chk(b, msp_pkg::CMD_WRITE[8*i +: 8]);
            end
        end
    endtask

    // Read frame compared with the settings the bench expects.
    task automatic rd(input logic [7:0] f, input logic [15:0] w, p, input logic [31:0] s,
        input logic [7:0] u);
        mk(f, w, p, s, u);
        put_code(msp_pkg::CMD_READ);
        host.idle();
        for (int i = 0; i < 16; i++) host.get(ans[i]);
        for (int i = 0; i < 4; i++) chk(ans[i], msp_pkg::CMD_READ[8*i +: 8]);
        for (int i = 0; i < 10; i++) chk(ans[i+4], pl[i]);
        chk({ans[15], ans[14]}, host.crc(pl));
    endtask

    // Step pulses ten cycles apart, counting rising edges of the pin.
    task automatic steps(input int k, output int rises);
        logic prev;
        rises = 0;
        prev = sync_out;
        repeat (k) begin
            step <= 1'b1;
            @(posedge clk);
            step <= 1'b0;
            repeat (9) begin
                @(posedge clk);
                rises += int'(sync_out === 1'b1 && prev === 1'b0);
                prev = sync_out;
            end
        end
    endtask

    // Defaults, a stalled write read back, then a corrupted write.
    task automatic t_settings();
        chk(sync_out, 1'b0);
        rd(msp_pkg::DEF_FLAGS, msp_pkg::DEF_WIDTH, msp_pkg::DEF_PERIOD, 32'h0, 8'h0);
        host.slow = 1'b1;
        wr(8'h02, 16'h1234, 16'h5678, 32'h89ABCDEF, 8'h5A, 1'b0);
        rd(8'h02, 16'h1234, 16'h5678, 32'h89ABCDEF, 8'h5A);
        host.slow = 1'b0;
        chk(sync_out, 1'b1);
        wr(8'h00, 16'h0001, 16'h0001, 32'h1, 8'h01, 1'b1);
        rd(8'h02, 16'h1234, 16'h5678, 32'h89ABCDEF, 8'h5A);
    endtask

    // Start pulse one microsecond wide, in both polarities.
    task automatic t_start();
        int n;
        for (int pol = 0; pol < 2; pol++) begin
            n = 0;
            wr(8'h11 | 8'(pol * 4), 16'h0001, 16'h0064, 32'h0, 8'h00, 1'b0);
            repeat (2) @(posedge clk);
            chk(sync_out, pol);
            moving <= 1'b1;
            repeat (260) begin
                @(posedge clk);
                n += int'(sync_out === ~pol[0]);
            end
            chk(n, msp_pkg::CYC_PER_UNIT);
            moving <= 1'b0;
            repeat (4) @(posedge clk);
        end
    endtask

    // Stop pulse whose width ends on the third step.
    task automatic t_stop();
        int r;
        wr(8'h29, 16'h0003, 16'h0064, 32'h0, 8'h00, 1'b0);
        moving <= 1'b1;
        repeat (4) @(posedge clk);
        moving <= 1'b0;
        repeat (4) @(posedge clk);
        steps(2, r);
        chk(sync_out, 1'b1);
        steps(1, r);
        chk(sync_out, 1'b0);
    endtask

    // Periodic pulses every fourth step, each one step wide.
    task automatic t_period();
        int r;
        wr(8'h49, 16'h0001, 16'h0004, 32'h0, 8'h00, 1'b0);
        steps(12, r);
        chk(r, 3);
    endtask

    // Window of five steps and three microsteps, both signs, both motor kinds.
    task automatic t_target();
        logic signed [31:0] es[5] = '{-32'sh5, 32'sh6, 32'sh0, 32'sh0, 32'sh2};
        logic signed [8:0] us[5] = '{9'sh3, 9'sh0, 9'sh4, 9'sh4, -9'sh3};
        logic sm[5] = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b1};
        logic ex[5] = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b1};
        wr(8'h00, 16'h000A, 16'h0064, 32'h00000005, 8'h03, 1'b0);
        for (int i = 0; i < 5; i++) begin
            err_s <= es[i];
            err_u <= us[i];
            stepper <= sm[i];
            repeat (3) @(posedge clk);
            chk(reached, ex[i]);
        end
    endtask

    // Reset for six cycles, then the scenarios in turn.
    initial begin
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        t_settings();
        t_start();
        t_stop();
        t_period();
        t_target();
        wrap_up();
    end

    // Watchdog well beyond the thousand or so cycles the scenarios need.
    initial begin
        repeat (20000) @(posedge clk);
        n_fail++;
        wrap_up();
    end
endmodule
